// ===== src/ltgw_ctrl.sv
// test button, ballast census and device pointer control of the lighting gateway
// assumes a wishbone classic master on clk_i and a dali framer that takes dev_cmd_o
//
// Local design decisions: register access over Wishbone and the register offsets.
module ltgw_ctrl #(
  parameter int unsigned P_TICK_CYC   = ltgw_pkg::TICK_CYC,
  parameter int unsigned P_SHORT_MS   = ltgw_pkg::SHORT_MS,
  parameter int unsigned P_LONG_MS    = ltgw_pkg::LONG_MS,
  parameter int unsigned P_TEST_TO_MS = ltgw_pkg::TEST_TO_MS,
  parameter int unsigned P_CENSUS_MS  = ltgw_pkg::CENSUS_MS
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // pins
  input  wire logic              btn_i,
  input  wire logic              bus_ok_i,
  output ltgw_pkg::ltgw_led_t    led_o,
  // dali side
  input  wire logic              census_done_i,
  input  wire logic [7:0]        census_count_i,
  output logic                   census_start_o,
  output logic                   census_busy_o,
  output logic                   mon_en_o,
  output logic                   test_mode_o,
  output logic      [7:0]        ch_a_lvl_o,
  output logic      [7:0]        ch_b_lvl_o,
  output ltgw_pkg::ltgw_cmd_t    dev_cmd_o
);
  import ltgw_pkg::*;

  localparam int unsigned FW = 10;

  function automatic logic [7:0] test_lvl(input ltgw_tmode_t m, input logic chan);
    test_lvl = ((m == LTGW_TM_B) == chan) ? LVL_MAX : LVL_OFF;
  endfunction

  function automatic logic in_flash(input logic [FW-1:0] ms, input int unsigned start);
    in_flash = (ms >= FW'(start)) && (ms < FW'(start + FLASH_ON_MS));
  endfunction

  // synchronisers and tick
  logic             btn_s1_q, btn_s2_q, bus_s1_q, bus_s2_q, bus_old_q;
  logic [15:0]      tick_q, tick_d;
  logic             tick;
  // button
  logic             btn_db_q, btn_db_d;
  logic [4:0]       deb_q, deb_d;
  logic [MS_W-1:0]  press_q, press_d;
  logic             long_q, long_d;
  logic             ev_short_q, ev_short_d, ev_med_q, ev_med_d, ev_long_q, ev_long_d;
  logic             mid;
  // test mode
  ltgw_tmode_t      tmode_q, tmode_d;
  logic [MS_W-1:0]  to_q, to_d;
  logic [FW-1:0]    fl_q, fl_d;
  ltgw_led_t        led_d;
  logic             test_exit;
  logic [7:0]       ch_a_d, ch_b_d;
  // census
  ltgw_cstate_t     cs_q, cs_d;
  logic [MS_W-1:0]  cs_ms_q, cs_ms_d;
  logic [7:0]       ref_q, ref_d;
  logic             cs_start_d, census_go;
  // registers
  logic             ack_d, wr, bus_rise;
  logic [31:0]      dat_d;
  logic [7:0]       lvl_a_q, lvl_a_d, lvl_b_q, lvl_b_d;
  logic [6:0]       ptr_a_q, ptr_a_d, ptr_b_q, ptr_b_d;
  logic [7:0]       dev_q [2*NDEV_CH];
  logic [7:0]       dev_d [2*NDEV_CH];
  ltgw_cmd_t        cmd_d;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      btn_s1_q  <= 1'b0;
      btn_s2_q  <= 1'b0;
      bus_s1_q  <= 1'b0;
      bus_s2_q  <= 1'b0;
      bus_old_q <= 1'b0;
    end
    else
    begin
      btn_s1_q  <= btn_i;
      btn_s2_q  <= btn_s1_q;
      bus_s1_q  <= bus_ok_i;
      bus_s2_q  <= bus_s1_q;
      bus_old_q <= bus_s2_q;
    end
  end

  assign tick     = (tick_q == 16'(P_TICK_CYC - 1));
  assign tick_d   = tick ? 16'h0000 : tick_q + 16'h0001;
  assign bus_rise = bus_s2_q & ~bus_old_q;

  // button: debounce, press length, events
  always_comb
  begin
    btn_db_d   = btn_db_q;
    deb_d      = deb_q;
    press_d    = press_q;
    long_d     = long_q;
    ev_short_d = 1'b0;
    ev_med_d   = 1'b0;
    ev_long_d  = 1'b0;
    if (btn_s2_q == btn_db_q)
      deb_d = 5'h00;
    else if (tick)
    begin
      if (deb_q == 5'(DEB_MS - 1))
      begin
        btn_db_d = btn_s2_q;
        deb_d    = 5'h00;
      end
      else
        deb_d = deb_q + 5'h01;
    end
    if (btn_db_q && !btn_db_d && !long_q)
    begin
      // short and medium are only known once released
      ev_short_d = (press_q < MS_W'(P_SHORT_MS));
      ev_med_d   = (press_q >= MS_W'(P_SHORT_MS));
    end
    if (btn_db_d && !btn_db_q)
    begin
      press_d = '0;
      long_d  = 1'b0;
    end
    else if (btn_db_q && tick && !long_q)
    begin
      press_d = press_q + MS_W'(1);
      if (press_d == MS_W'(P_LONG_MS))
      begin
        long_d    = 1'b1;
        ev_long_d = 1'b1;
      end
    end
  end

  assign mid = btn_db_q && !long_q && (press_q >= MS_W'(P_SHORT_MS));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_q     <= 16'h0000;
      btn_db_q   <= 1'b0;
      deb_q      <= 5'h00;
      press_q    <= '0;
      long_q     <= 1'b0;
      ev_short_q <= 1'b0;
      ev_med_q   <= 1'b0;
      ev_long_q  <= 1'b0;
    end
    else
    begin
      tick_q     <= tick_d;
      btn_db_q   <= btn_db_d;
      deb_q      <= deb_d;
      press_q    <= press_d;
      long_q     <= long_d;
      ev_short_q <= ev_short_d;
      ev_med_q   <= ev_med_d;
      ev_long_q  <= ev_long_d;
    end
  end

  // test mode, indicators and channel outputs
  always_comb
  begin
    tmode_d   = tmode_q;
    to_d      = to_q;
    fl_d      = fl_q;
    test_exit = 1'b0;
    case (tmode_q)
      LTGW_TM_OFF:
        if (ev_med_q)
          tmode_d = LTGW_TM_A;
      LTGW_TM_A, LTGW_TM_B:
        if (ev_med_q || (tick && to_q == MS_W'(P_TEST_TO_MS - 1)))
          test_exit = 1'b1;
        else if (ev_short_q)
          tmode_d = (tmode_q == LTGW_TM_A) ? LTGW_TM_B : LTGW_TM_A;
      default:
        tmode_d = LTGW_TM_OFF;
    endcase
    if (test_exit)
      tmode_d = LTGW_TM_OFF;
    if (tmode_q == LTGW_TM_OFF || btn_db_q)
      to_d = '0;
    else if (tick)
      to_d = to_q + MS_W'(1);
    if (tmode_q == LTGW_TM_OFF)
      fl_d = '0;
    else if (tick)
      fl_d = (fl_q == FW'(FLASH_MS - 1)) ? '0 : fl_q + FW'(1);
    // green goes dark/bright already at the 2 s mark, the mode changes on release
    led_d.green  = (tmode_q == LTGW_TM_OFF) ? !mid : mid;
    led_d.yellow = (tmode_q != LTGW_TM_OFF) && (in_flash(fl_q, 0) ||
                   (tmode_q == LTGW_TM_B && in_flash(fl_q, FLASH_2ND_MS)));
    // background levels are not written in test and stay off the outputs
    ch_a_d = (tmode_q != LTGW_TM_OFF) ? test_lvl(tmode_q, 1'b0) : lvl_a_q;
    ch_b_d = (tmode_q != LTGW_TM_OFF) ? test_lvl(tmode_q, 1'b1) : lvl_b_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tmode_q    <= LTGW_TM_OFF;
      to_q       <= '0;
      fl_q       <= '0;
      led_o      <= '{green: 1'b1, yellow: 1'b0};
      ch_a_lvl_o <= LVL_OFF;
      ch_b_lvl_o <= LVL_OFF;
    end
    else
    begin
      tmode_q    <= tmode_d;
      to_q       <= to_d;
      fl_q       <= fl_d;
      led_o      <= led_d;
      ch_a_lvl_o <= ch_a_d;
      ch_b_lvl_o <= ch_b_d;
    end
  end

  assign test_mode_o = (tmode_q != LTGW_TM_OFF);

  // census: started only by the object or a long press, never on power return
  always_comb
  begin
    cs_d       = cs_q;
    cs_ms_d    = cs_ms_q;
    ref_d      = ref_q;
    cs_start_d = 1'b0;
    case (cs_q)
      LTGW_CS_IDLE:
        if (census_go || ev_long_q)
        begin
          cs_d       = LTGW_CS_RUN;
          cs_ms_d    = '0;
          cs_start_d = 1'b1;
        end
      LTGW_CS_RUN:
        if (census_done_i || (tick && cs_ms_q == MS_W'(P_CENSUS_MS - 1)))
        begin
          cs_d  = LTGW_CS_IDLE;
          ref_d = census_count_i;
        end
        else if (tick)
          cs_ms_d = cs_ms_q + MS_W'(1);
      default:
        cs_d = LTGW_CS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cs_q           <= LTGW_CS_IDLE;
      cs_ms_q        <= '0;
      ref_q          <= 8'h00;
      census_start_o <= 1'b0;
    end
    else
    begin
      cs_q           <= cs_d;
      cs_ms_q        <= cs_ms_d;
      ref_q          <= ref_d;
      census_start_o <= cs_start_d;
    end
  end

  assign census_busy_o = (cs_q == LTGW_CS_RUN);
  // monitoring depends only on a known reference, never on lamp state
  assign mon_en_o = (ref_q != 8'h00);

  // wishbone register file; a write commits at the edge where the master sees ack
  assign wr        = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
                     (tmode_q == LTGW_TM_OFF);
  assign census_go = wr && (wb_adr_i == REG_CENSUS) && wb_dat_i[CENSUS_GO_BIT];

  always_comb
  begin
    ack_d   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    lvl_a_d = lvl_a_q;
    lvl_b_d = lvl_b_q;
    ptr_a_d = ptr_a_q;
    ptr_b_d = ptr_b_q;
    dev_d   = dev_q;
    cmd_d   = '0;
    dat_d   = 32'h0000_0000;
    if (wr)
      case (wb_adr_i)
        REG_LVL_A, REG_LVL_B:
        begin
          cmd_d = '{valid: 1'b1, chan: wb_adr_i[2], bcast: 1'b1, addr: 6'h00,
                    level: wb_dat_i[7:0]};
          if (wb_adr_i[2])
            lvl_b_d = wb_dat_i[7:0];
          else
            lvl_a_d = wb_dat_i[7:0];
          for (int i = 0; i < NDEV_CH; i++)
            dev_d[{wb_adr_i[2], 6'(i)}] = wb_dat_i[7:0];
        end
        REG_PTR_A:
          ptr_a_d = wb_dat_i[6:0];
        REG_PTR_B:
          ptr_b_d = wb_dat_i[6:0];
        REG_SEL_A, REG_SEL_B:
        begin
          if (!(wb_adr_i[2] ? ptr_b_q[PTR_NONE_BIT] : ptr_a_q[PTR_NONE_BIT]))
          begin
            cmd_d = '{valid: 1'b1, chan: wb_adr_i[2], bcast: 1'b0,
                      addr: wb_adr_i[2] ? ptr_b_q[5:0] : ptr_a_q[5:0],
                      level: wb_dat_i[7:0]};
            dev_d[{cmd_d.chan, cmd_d.addr}] = wb_dat_i[7:0];
          end
        end
        REG_DEV_A:
          if (wb_sel_i[1])
          begin
            cmd_d = '{valid: 1'b1, chan: 1'b0, bcast: 1'b0,
                      addr: wb_dat_i[DEV_IDX_LSB +: 6], level: wb_dat_i[7:0]};
            dev_d[{1'b0, cmd_d.addr}] = wb_dat_i[7:0];
          end
        default:
          cmd_d = '0;
      endcase
    if (test_exit)
    begin
      // devices keep what the test left on them
      lvl_a_d = test_lvl(tmode_q, 1'b0);
      lvl_b_d = test_lvl(tmode_q, 1'b1);
      for (int i = 0; i < 2 * NDEV_CH; i++)
        dev_d[i] = test_lvl(tmode_q, i >= NDEV_CH);
    end
    // pointer survives test end; bus voltage return clears it, as does the system reset
    if (bus_rise)
    begin
      ptr_a_d = PTR_NONE;
      ptr_b_d = PTR_NONE;
    end
    case (wb_adr_i)
      REG_CENSUS:
        dat_d[CENSUS_GO_BIT] = census_busy_o;
      REG_STATUS:
      begin
        dat_d[ST_TMODE_LSB +: 2] = tmode_q;
        dat_d[ST_YEL_BIT]        = led_o.yellow;
        dat_d[ST_GRN_BIT]        = led_o.green;
        dat_d[ST_BUSY_BIT]       = census_busy_o;
        dat_d[ST_REF_LSB +: 8]   = ref_q;
      end
      REG_LVL_A:
        dat_d[7:0] = lvl_a_q;
      REG_LVL_B:
        dat_d[7:0] = lvl_b_q;
      REG_PTR_A:
        dat_d[6:0] = ptr_a_q;
      REG_PTR_B:
        dat_d[6:0] = ptr_b_q;
      REG_SEL_A:
        dat_d[7:0] = ptr_a_q[PTR_NONE_BIT] ? LVL_OFF : dev_q[{1'b0, ptr_a_q[5:0]}];
      REG_SEL_B:
        dat_d[7:0] = ptr_b_q[PTR_NONE_BIT] ? LVL_OFF : dev_q[{1'b1, ptr_b_q[5:0]}];
      default:
        dat_d = 32'h0000_0000;
    endcase
  end

  // pointer resets with the system reset and on bus voltage return, so a download leaves it alone
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      lvl_a_q   <= LVL_OFF;
      lvl_b_q   <= LVL_OFF;
      ptr_a_q   <= PTR_NONE;
      ptr_b_q   <= PTR_NONE;
      dev_q     <= '{default: 8'h00};
      dev_cmd_o <= '0;
    end
    else
    begin
      wb_ack_o  <= ack_d;
      wb_dat_o  <= dat_d;
      lvl_a_q   <= lvl_a_d;
      lvl_b_q   <= lvl_b_d;
      ptr_a_q   <= ptr_a_d;
      ptr_b_q   <= ptr_b_d;
      dev_q     <= dev_d;
      dev_cmd_o <= cmd_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_census_one_starts: assert property (census_go && cs_q == LTGW_CS_IDLE
    |=> census_start_o && census_busy_o) else $error("census not started");
  a_census_cause: assert property (census_start_o
    |-> $past(census_go || ev_long_q)) else $error("census started unasked");
  a_census_bound: assert property (census_busy_o
    |-> cs_ms_q < MS_W'(P_CENSUS_MS)) else $error("census overran");
  a_long_keeps_mode: assert property (ev_long_q && cs_q == LTGW_CS_IDLE
    |=> census_start_o && tmode_q == $past(tmode_q)) else $error("long press");
  a_test_entry: assert property (tmode_q == LTGW_TM_OFF && ev_med_q
    |=> tmode_q == LTGW_TM_A ##1 ch_a_lvl_o == LVL_MAX && ch_b_lvl_o == LVL_OFF)
    else $error("test entry levels wrong");
  a_short_to_b: assert property (tmode_q == LTGW_TM_A && ev_short_q
    |=> tmode_q == LTGW_TM_B) else $error("short press did not select b");
  a_green_dark: assert property (tmode_q == LTGW_TM_OFF && mid
    |=> !led_o.green) else $error("green not dark");
  a_double_flash: assert property (tmode_q == LTGW_TM_B && fl_q == FW'(FLASH_2ND_MS)
    |=> led_o.yellow) else $error("no second flash");
  a_single_flash: assert property (tmode_q == LTGW_TM_A && fl_q == FW'(FLASH_2ND_MS)
    |=> !led_o.yellow) else $error("extra flash on a");
  a_test_blocks_bus: assert property (test_mode_o && wb_cyc_i && wb_stb_i && wb_we_i
    && !test_exit && !bus_rise |=> $stable(lvl_a_q) && $stable(ptr_a_q))
    else $error("telegram run in test");
  a_timeout_exit: assert property (test_mode_o && !ev_med_q && tick
    && to_q == MS_W'(P_TEST_TO_MS - 1) |=> !test_mode_o) else $error("no timeout");
  a_ptr_clear: assert property (bus_rise
    |=> ptr_a_q == PTR_NONE && ptr_b_q == PTR_NONE) else $error("ptr kept");

  c_test_enter: cover property (tmode_q == LTGW_TM_OFF ##1 tmode_q == LTGW_TM_A);
  c_census_done: cover property (census_busy_o ##1 !census_busy_o);
  c_sel_write: cover property (dev_cmd_o.valid && !dev_cmd_o.bcast);
  c_test_b: cover property (tmode_q == LTGW_TM_B);
endmodule

// ===== src/ltgw_pkg.sv
// constants, register map and types of the lighting gateway test/select control
// assumes one 40 MHz clock, a classic wishbone master and an external dali framer
package ltgw_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TICK_US     = 1000;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned DEB_MS      = 20;
  localparam int unsigned SHORT_S     = 2;
  localparam int unsigned LONG_S      = 5;
  localparam int unsigned TEST_TO_MIN = 5;
  localparam int unsigned CENSUS_S    = 60;
  localparam int unsigned FLASH_HZ    = 1;
  localparam int unsigned SHORT_MS    = SHORT_S * 1000;
  localparam int unsigned LONG_MS     = LONG_S * 1000;
  localparam int unsigned TEST_TO_MS  = TEST_TO_MIN * 60 * 1000;
  localparam int unsigned CENSUS_MS   = CENSUS_S * 1000;
  localparam int unsigned FLASH_MS    = 1000 / FLASH_HZ;
  localparam int unsigned FLASH_ON_MS = 200;
  localparam int unsigned FLASH_2ND_MS = 400;
  localparam int unsigned MS_W        = 19;
  localparam int unsigned NDEV_CH     = 64;

  // register byte addresses
  localparam logic [7:0] REG_CENSUS = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LVL_A  = 8'h08;
  localparam logic [7:0] REG_LVL_B  = 8'h0C;
  localparam logic [7:0] REG_PTR_A  = 8'h10;
  localparam logic [7:0] REG_PTR_B  = 8'h14;
  localparam logic [7:0] REG_SEL_A  = 8'h18;
  localparam logic [7:0] REG_SEL_B  = 8'h1C;
  localparam logic [7:0] REG_DEV_A  = 8'h20;

  // field positions
  localparam int unsigned CENSUS_GO_BIT = 0;
  localparam int unsigned ST_TMODE_LSB  = 0;
  localparam int unsigned ST_YEL_BIT    = 2;
  localparam int unsigned ST_GRN_BIT    = 3;
  localparam int unsigned ST_BUSY_BIT   = 4;
  localparam int unsigned ST_REF_LSB    = 8;
  localparam int unsigned PTR_NONE_BIT  = 6;
  localparam int unsigned DEV_IDX_LSB   = 8;

  // reset and fixed values
  localparam logic [6:0] PTR_NONE = 7'h40;
  localparam logic [7:0] LVL_MAX  = 8'hFE;
  localparam logic [7:0] LVL_OFF  = 8'h00;

  typedef enum logic [1:0] {
    LTGW_TM_OFF = 2'b00,
    LTGW_TM_A   = 2'b01,
    LTGW_TM_B   = 2'b11
  } ltgw_tmode_t;

  typedef enum logic {
    LTGW_CS_IDLE = 1'b0,
    LTGW_CS_RUN  = 1'b1
  } ltgw_cstate_t;

  typedef struct packed {
    logic       valid;
    logic       chan;
    logic       bcast;
    logic [5:0] addr;
    logic [7:0] level;
  } ltgw_cmd_t;

  typedef struct packed {
    logic green;
    logic yellow;
  } ltgw_led_t;
endpackage

// ===== tb/ltgw_dali_model.sv
// census responder standing in for the dali lines of the lighting gateway
// assumes the start pulse and done pulse share clk_i with the control block
module ltgw_dali_model #(
  parameter int unsigned P_DLY = 20
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // census handshake
  input  wire logic       start_i,
  input  wire logic [7:0] cnt_i,
  output logic            done_o,
  output logic [7:0]      count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned n_q;
  logic        run_q;

  // count only valid with done; otherwise inverted so a stale sample is caught
  assign count_o = done_o ? cnt_i : ~cnt_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q  <= 1'b0;
      n_q    <= 0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        run_q <= 1'b1;
        n_q   <= 0;
      end
      else if (run_q)
      begin
        n_q <= n_q + 1;
        if (n_q == P_DLY)
        begin
          run_q  <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== tb/test_lighting_gateway_test_select_ctrl.sv
// self-checking bench of the gateway control with shortened tick and press lengths
// assumes 4 cycles per tick, 20 tick debounce, presses of 24, 40 and 85 ticks
module test_lighting_gateway_test_select_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import ltgw_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} ltgw_row_t;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, btn_i = 0, bus_ok_i = 1;
  logic [7:0]  wb_adr_i = 0, cnt = 0, ccount, cha, chb;
  logic [3:0]  wb_sel_i = 0, sel = 4'hF;
  ltgw_cmd_t   cmd, cmd_last;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic        wb_ack_o, cdone, cstart, cbusy, mon, tmode;
  ltgw_led_t   led;
  int          error_cnt = 0, n_checks = 0;
  ltgw_row_t   rows [9] = '{
    '{1, REG_LVL_A, 32'h80, 32'h80}, '{1, REG_LVL_B, 32'h3C, 32'h3C},
    '{1, REG_PTR_A, 32'h05, 32'h05}, '{1, REG_SEL_A, 32'h33, 32'h33},
    '{1, REG_PTR_B, 32'h40, 32'h40}, '{1, REG_SEL_B, 32'h55, 32'h00},
    '{1, REG_DEV_A, 32'h0577, 32'h00}, '{0, REG_SEL_A, 32'h00, 32'h77},
    '{1, 8'h30, 32'hFF, 32'h00}};

  ltgw_ctrl #(.P_TICK_CYC(4), .P_SHORT_MS(30), .P_LONG_MS(60), .P_TEST_TO_MS(200),
              .P_CENSUS_MS(100)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .btn_i(btn_i), .bus_ok_i(bus_ok_i),
    .led_o(led), .census_done_i(cdone), .census_count_i(ccount),
    .census_start_o(cstart), .census_busy_o(cbusy), .mon_en_o(mon),
    .test_mode_o(tmode), .ch_a_lvl_o(cha), .ch_b_lvl_o(chb), .dev_cmd_o(cmd));
  ltgw_dali_model MDL (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(cstart), .cnt_i(cnt),
    .done_o(cdone), .count_o(ccount));

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  // the command pulse lasts one cycle, so keep the last one seen
  always @(posedge clk_i)
  begin
    if (cmd.valid)
      cmd_last <= cmd;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // holds the request until ack is sampled, data taken at that same edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      chk(32'h0, 32'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // debounced press must outlast 20 ticks; release wait covers debounce
  task automatic press(input int ticks);
    btn_i <= 1'b1;
    repeat (ticks * 4) @(posedge clk_i);
    btn_i <= 1'b0;
    repeat (120) @(posedge clk_i);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, REG_STATUS, 0);
    chk(q, 32'h08);
    wb(0, REG_PTR_A, 0);
    chk(q, 32'h40);
    $display("test reset done");
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wb(1, rows[i].a, rows[i].d);
      wb(0, rows[i].a, 0);
      chk(q, rows[i].e);
    end
    chk(32'(chb), 32'h3C);
    chk(32'(cbusy), 32'h0);
    chk(32'(cmd_last), 32'h10577);
    $display("test table done");
    wb(1, REG_CENSUS, 32'h0);
    chk(32'(cbusy), 32'h0);
    cnt <= 8'h07;
    wb(1, REG_CENSUS, 32'h1);
    chk(32'(cbusy), 32'h1);
    repeat (40) @(posedge clk_i);
    wb(0, REG_STATUS, 0);
    chk(q, 32'h0708);
    chk(32'(mon), 32'h1);
    $display("test census done");
    press(40);
    chk(32'(tmode), 32'h1);
    chk(32'(led.green), 32'h0);
    chk({cha, chb}, 16'hFE00);
    wb(1, REG_LVL_A, 32'h10);
    chk(32'(cha), 32'hFE);
    chk(32'(cmd_last), 32'h10577);
    press(24);
    chk({cha, chb}, 16'h00FE);
    cnt <= 8'h09;
    press(85);
    wb(0, REG_STATUS, 0);
    chk(q & 32'hFF03, 32'h0903);
    press(40);
    chk(32'(tmode), 32'h0);
    chk(32'(led.green), 32'h1);
    chk({cha, chb}, 16'h00FE);
    wb(0, REG_LVL_B, 0);
    chk(q, 32'hFE);
    wb(0, REG_PTR_A, 0);
    chk(q, 32'h05);
    $display("test mode done");
    press(40);
    repeat (600) @(posedge clk_i);
    chk(32'(tmode), 32'h1);
    chk(32'(led.yellow), 32'h1);
    repeat (300) @(posedge clk_i);
    chk(32'(tmode), 32'h0);
    chk(32'(led.yellow), 32'h0);
    $display("test timeout done");
    bus_ok_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    bus_ok_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    wb(0, REG_PTR_A, 0);
    chk(q, 32'h40);
    chk(32'(cbusy), 32'h0);
    $display("test bus recovery done");
    sel = 4'h2;
    wb(1, REG_LVL_B, 32'h11);
    sel = 4'h1;
    wb(1, REG_DEV_A, 32'h0512);
    sel = 4'hF;
    wb(0, REG_LVL_B, 0);
    chk(q, 32'h00);
    wb(1, REG_PTR_A, 32'h05);
    wb(0, REG_SEL_A, 0);
    chk(q, 32'hFE);
    $display("test lane refusal done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, REG_PTR_A, 0);
    chk(q, 32'h40);
    wb(0, REG_STATUS, 0);
    chk(q, 32'h08);
    chk(32'(mon), 32'h0);
    $display("test mid reset done");
    print_verdict();
  end
endmodule
